// file: logic/vpi_pkg.sv
package vpi_pkg;

  // Register byte offsets on the APB port.
  localparam logic [7:0] VPI_CTRL_OFS = 8'h00;
  localparam logic [7:0] VPI_STAT_OFS = 8'h04;
  localparam logic [7:0] VPI_TIME_OFS = 8'h08;
  localparam logic [7:0] VPI_SADR_OFS = 8'h0c;

  // Control register field positions.
  localparam int VPI_CTRL_FMT422 = 0;
  localparam int VPI_CTRL_RGB = 1;
  localparam int VPI_CTRL_ASYNC = 2;
  localparam int VPI_CTRL_EMBED = 3;
  localparam int VPI_CTRL_CLKOUT = 4;
  localparam int VPI_CTRL_PROG = 5;
  localparam int VPI_CTRL_CAPEN = 6;
  localparam logic [6:0] VPI_CTRL_RST = 7'h60;

  // Status register field positions.
  localparam int VPI_STAT_OVF = 0;
  localparam int VPI_STAT_PHASE = 1;
  localparam int VPI_STAT_ADDR_LSB_SELECT = 2;
  localparam int VPI_STAT_RD = 3;
  localparam int VPI_STAT_AVLD = 4;
  localparam int VPI_STAT_LVL = 8;

  // Pixel and buffer geometry.
  localparam int VPI_CW = 10;
  localparam int VPI_FIFO_DEPTH = 16;
  localparam int VPI_LVL_W = 5;

  // Embedded timing code values and status-word bit positions.
  localparam logic [9:0] VPI_CODE_ONES = 10'h3ff;
  localparam logic [9:0] VPI_CODE_ZERO = 10'h000;
  localparam int VPI_XYZ_V = 7;
  localparam int VPI_XYZ_H = 6;

  // Serial line glitch rejection.
  localparam int VPI_CLK_NS = 20;
  localparam int VPI_GLITCH_NS = 50;
  localparam int VPI_GLITCH_CYC = (VPI_GLITCH_NS + VPI_CLK_NS - 1) / VPI_CLK_NS;
  localparam logic [1:0] VPI_GLITCH_CNT = 2'(VPI_GLITCH_CYC - 1);

  // One pixel as it leaves towards the converters.
  typedef struct packed {
    logic blank;
    logic vsync;
    logic hsync;
    logic [VPI_CW-1:0] a;
    logic [VPI_CW-1:0] b;
    logic [VPI_CW-1:0] c;
  } vpi_pix_t;

  localparam int VPI_PIX_W = $bits(vpi_pix_t);

  // Chroma multiplex phase in the two-port format.
  typedef enum logic {VPI_PH_BLUE, VPI_PH_RED} vpi_phase_t;

endpackage : vpi_pkg

// file: logic/vpi_fifo.sv
`timescale 1ns/1ps
module vpi_fifo #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 16,
  parameter int LW = 5
) (
  input wire logic sys_clk,            // System clock.
  input wire logic nrst,               // Synchronous reset, active low.
  input wire logic wr_valid,           // Write request.
  output logic wr_ready,               // Room for a word.
  input wire logic [WIDTH-1:0] wr_data, // Word to store.
  output logic rd_valid,               // Output register holds a word.
  input wire logic rd_ready,           // Drain accepts the word.
  output logic [WIDTH-1:0] rd_data,    // Registered output word.
  output logic [LW-1:0] level          // Words held in the array.
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [LW-1:0] cnt_r;
  logic do_wr;
  logic do_rd;

  // The output register reloads when it is empty or being taken.
  assign wr_ready = (cnt_r != LW'(DEPTH));
  assign do_wr = wr_valid && wr_ready;
  assign do_rd = (cnt_r != '0) && (!rd_valid || rd_ready);
  assign level = cnt_r;

  // Storage array.
  always_ff @(posedge sys_clk) begin
    if (do_wr) begin
      mem[wp_r] <= wr_data;
    end
  end

  // Pointers and fill count.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (do_wr) begin
        wp_r <= wp_r + 1'b1;
      end
      if (do_rd) begin
        rp_r <= rp_r + 1'b1;
      end
      cnt_r <= cnt_r + LW'(do_wr) - LW'(do_rd);
    end
  end

  // Registered read side.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rd_valid <= 1'b0;
      rd_data <= '0;
    end else if (do_rd) begin
      rd_valid <= 1'b1;
      rd_data <= mem[rp_r];
    end else if (rd_ready) begin
      rd_valid <= 1'b0;
    end
  end
endmodule : vpi_fifo

// file: logic/vpi_top.sv
// Overview of operation
// - Capture one pixel per pixel clock rise: three ports, or two in 4:2:2.
// - Luma port gives Y for YCrCb input and green for RGB input.
// - Red-difference port gives red for RGB; ignored in 4:2:2 format.
// - In 4:2:2 the shared chroma port alternates Cb and Cr; device splits them.
// - Active-low reset restarts timing generator and restores default settings.
// - Blanking/clock pin is blank input, or clock output in progressive mode only.
// - Line-sync pin is active-low hsync, or composite sync in async mode.
// - Frame-sync pin is active-low vsync, or secondary sync in async mode.
// - Sync insertion follows external pulses or embedded EAV/SAV codes.
// - Luma goes to first converter, colour channels to second and third.
// - Second converter carries red-difference port, or Cr of the shared port in 4:2:2; third the shared chroma port.
// - Address-select pin sets the serial port's address least bit.
// - With address-select high, serial lines reject glitches under 50 ns.
// - Last bit of serial address byte: one reads, zero writes.
`timescale 1ns/1ps
module vpi_top (
  input wire logic sys_clk,                        // System clock, 50 MHz.
  input wire logic nrst,                           // Synchronous reset, active low.
  input wire logic psel,                           // APB select.
  input wire logic penable,                        // APB enable.
  input wire logic pwrite,                         // APB direction.
  input wire logic [7:0] paddr,                    // APB byte address.
  input wire logic [31:0] pwdata,                  // APB write data.
  output logic [31:0] prdata,                      // APB read data.
  output logic pready,                             // APB ready.
  output logic pslverr,                            // APB error on unmapped address.
  input wire logic pixel_clock_input,              // Pixel clock pin.
  input wire logic [vpi_pkg::VPI_CW-1:0] luma_port, // Luma or green pins.
  input wire logic [vpi_pkg::VPI_CW-1:0] red_diff_port, // Red-difference or red pins.
  input wire logic [vpi_pkg::VPI_CW-1:0] shared_chroma_port, // Chroma or blue pins.
  input wire logic line_sync_n,                    // Hsync or composite sync pin.
  input wire logic async_secondary_sync,           // Vsync or secondary sync pin.
  input wire logic blank_or_clock_out_in,          // Blank pin level seen.
  output logic blank_or_clock_out_out,             // Clock driven on blank pin.
  output logic blank_or_clock_out_oe,              // Drive enable of blank pin.
  input wire logic addr_lsb_select,                // Serial address select pin.
  input wire logic ser_clk_in,                     // Serial clock pin.
  input wire logic ser_data_in,                    // Serial data pin.
  output logic ser_clk_filt,                       // Filtered serial clock.
  output logic ser_data_filt,                      // Filtered serial data.
  output logic ser_addr_lsb,                       // Address least bit for the port.
  output logic pix_valid,                          // Converter word valid.
  input wire logic pix_ready,                      // Converter takes word.
  output vpi_pkg::vpi_pix_t pix_out                // Converter word.
);
  import vpi_pkg::*;

  // Control and status state.
  logic [6:0] ctrl_r;
  logic ovf_r;
  logic [15:0] pcnt_r;
  logic [15:0] lcnt_r;
  logic [7:0] sadr_r;
  logic sadr_vld_r;
  vpi_phase_t phase_r;

  // Pin synchronisers, two stages each.
  logic [VPI_CW*3+4-1:0] pin_s1_r;
  logic [VPI_CW*3+4-1:0] pin_s2_r;
  logic pclk_prev_r;
  logic [2:0] misc_s1_r;
  logic [2:0] misc_s2_r;
  logic [VPI_CW-1:0] y_s;
  logic [VPI_CW-1:0] cr_s;
  logic [VPI_CW-1:0] cc_s;
  logic hs_s;
  logic vs_s;
  logic bk_s;
  logic pclk_s;
  logic pix_edge;

  // Pixel assembly state.
  logic [VPI_CW-1:0] cb_hold_r;
  logic [VPI_CW-1:0] cr_hold_r;
  logic [VPI_CW-1:0] y_d1_r;
  logic [VPI_CW-1:0] y_d2_r;
  logic [VPI_CW-1:0] y_d3_r;
  logic hs_prev_r;
  logic ls_pend_r;
  logic vs_prev_r;
  logic emb_h_r;
  logic emb_v_r;
  logic line_start;
  logic code_seen;
  vpi_pix_t pix_nxt;
  logic push;
  logic fifo_wr_ready;
  logic [VPI_LVL_W-1:0] fifo_level;

  // Serial line filter and address capture state.
  logic [1:0] gcnt_clk_r;
  logic [1:0] gcnt_dat_r;
  logic scl_prev_r;
  logic sda_prev_r;
  logic [3:0] sbit_r;
  logic [7:0] sshift_r;
  logic sbusy_r;

  // APB state.
  logic apb_acc;
  logic apb_wr;

  // Lets a serial line level through once it has held long enough, used twice.
  function automatic logic glitch_pass(input logic raw, input logic cur,
                                       input logic [1:0] cnt, input logic en);
    glitch_pass = !en || (raw != cur && cnt == VPI_GLITCH_CNT);
  endfunction : glitch_pass

  // Decodes an APB byte address into a known register.
  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == VPI_CTRL_OFS) || (a == VPI_STAT_OFS) ||
              (a == VPI_TIME_OFS) || (a == VPI_SADR_OFS);
  endfunction : reg_hit

  // Pin capture through two flip-flops before any logic reads it.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      misc_s1_r <= 3'h7;
      misc_s2_r <= 3'h7;
      pclk_prev_r <= 1'b0;
    end else begin
      pin_s1_r <= {pixel_clock_input, line_sync_n, async_secondary_sync,
                   blank_or_clock_out_in, luma_port, red_diff_port, shared_chroma_port};
      pin_s2_r <= pin_s1_r;
      misc_s1_r <= {addr_lsb_select, ser_clk_in, ser_data_in};
      misc_s2_r <= misc_s1_r;
      pclk_prev_r <= pclk_s;
    end
  end

  assign {pclk_s, hs_s, vs_s, bk_s, y_s, cr_s, cc_s} = pin_s2_r;
  assign pix_edge = pclk_s && !pclk_prev_r;

  // Line start comes from a falling line-sync or an embedded start code.
  assign code_seen = (y_d3_r == VPI_CODE_ONES) && (y_d2_r == VPI_CODE_ZERO) &&
                     (y_d1_r == VPI_CODE_ZERO);
  assign line_start = ctrl_r[VPI_CTRL_EMBED] ? (code_seen && !y_s[VPI_XYZ_H])
                                             : (ls_pend_r || (hs_prev_r && !hs_s));

  // Software control register, back to defaults on reset.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ctrl_r <= VPI_CTRL_RST;
    end else if (apb_wr && paddr == VPI_CTRL_OFS) begin
      ctrl_r <= pwdata[6:0];
    end
  end

  // Line-sync history on every clock; frame-sync history and embedded code tracking on each pixel.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      hs_prev_r <= 1'b1;
      ls_pend_r <= 1'b0;
      vs_prev_r <= 1'b1;
      y_d1_r <= '0;
      y_d2_r <= '0;
      y_d3_r <= '0;
      emb_h_r <= 1'b0;
      emb_v_r <= 1'b0;
    end else begin
      // Line sync may fall while the pixel clock rests, so hold it for the next pixel.
      hs_prev_r <= hs_s;
      ls_pend_r <= pix_edge ? 1'b0 : (ls_pend_r || (hs_prev_r && !hs_s));
      if (pix_edge) begin
        vs_prev_r <= vs_s;
        y_d1_r <= y_s;
        y_d2_r <= y_d1_r;
        y_d3_r <= y_d2_r;
        if (code_seen) begin
          emb_h_r <= y_s[VPI_XYZ_H];
          emb_v_r <= y_s[VPI_XYZ_V];
        end
      end
    end
  end

  // Chroma demultiplex, restarting on blue at each line start.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      phase_r <= VPI_PH_BLUE;
      cb_hold_r <= '0;
      cr_hold_r <= '0;
    end else if (pix_edge) begin
      if (line_start || phase_r == VPI_PH_BLUE) begin
        cb_hold_r <= cc_s;
        phase_r <= VPI_PH_RED;
      end else begin
        cr_hold_r <= cc_s;
        phase_r <= VPI_PH_BLUE;
      end
    end
  end

  // Timing generator counting pixels per line and lines per frame.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pcnt_r <= '0;
      lcnt_r <= '0;
    end else if (pix_edge) begin
      pcnt_r <= line_start ? 16'h0000 : pcnt_r + 16'h0001;
      if (ctrl_r[VPI_CTRL_EMBED] ? (code_seen && emb_v_r && !y_s[VPI_XYZ_V])
                                 : (vs_prev_r && !vs_s)) begin
        lcnt_r <= '0;
      end else if (line_start) begin
        lcnt_r <= lcnt_r + 16'h0001;
      end
    end
  end

  // Builds the converter word from the current pixel and sync mode.
  always_comb begin
    pix_nxt = '0;
    pix_nxt.a = y_s;
    if (ctrl_r[VPI_CTRL_FMT422]) begin
      pix_nxt.b = (phase_r == VPI_PH_RED && !line_start) ? cc_s : cr_hold_r;
      pix_nxt.c = (phase_r == VPI_PH_RED && !line_start) ? cb_hold_r : cc_s;
    end else begin
      pix_nxt.b = cr_s;
      pix_nxt.c = cc_s;
    end
    if (ctrl_r[VPI_CTRL_EMBED]) begin
      pix_nxt.hsync = emb_h_r;
      pix_nxt.vsync = emb_v_r;
      pix_nxt.blank = emb_h_r || emb_v_r;
    end else begin
      pix_nxt.hsync = !hs_s;
      pix_nxt.vsync = ctrl_r[VPI_CTRL_ASYNC] ? vs_s : !vs_s;
      pix_nxt.blank = blank_or_clock_out_oe ? 1'b0 : bk_s;
    end
  end

  // A pixel is pushed on each edge while capture is enabled and room exists.
  assign push = pix_edge && ctrl_r[VPI_CTRL_CAPEN] && fifo_wr_ready;

  // Overflow is sticky; a new loss wins over a software clear.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ovf_r <= 1'b0;
    end else if (pix_edge && ctrl_r[VPI_CTRL_CAPEN] && !fifo_wr_ready) begin
      ovf_r <= 1'b1;
    end else if (apb_wr && paddr == VPI_STAT_OFS && pwdata[VPI_STAT_OVF]) begin
      ovf_r <= 1'b0;
    end
  end

  // Pixel buffer toward the converters.
  vpi_fifo #(
    .WIDTH(VPI_PIX_W),
    .DEPTH(VPI_FIFO_DEPTH),
    .LW(VPI_LVL_W)
  ) u_fifo (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .wr_valid(push),
    .wr_ready(fifo_wr_ready),
    .wr_data(pix_nxt),
    .rd_valid(pix_valid),
    .rd_ready(pix_ready),
    .rd_data(pix_out),
    .level(fifo_level)
  );

  // Shared pin drives the pixel clock out only in progressive mode.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      blank_or_clock_out_oe <= 1'b0;
      blank_or_clock_out_out <= 1'b0;
    end else begin
      blank_or_clock_out_oe <= ctrl_r[VPI_CTRL_CLKOUT] && ctrl_r[VPI_CTRL_PROG];
      blank_or_clock_out_out <= pclk_s;
    end
  end

  // Address select sets the serial slave address least bit.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ser_addr_lsb <= 1'b0;
    end else begin
      ser_addr_lsb <= misc_s2_r[2];
    end
  end

  // Glitch filter: with select high a level must hold three cycles to pass.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ser_clk_filt <= 1'b1;
      ser_data_filt <= 1'b1;
      gcnt_clk_r <= '0;
      gcnt_dat_r <= '0;
    end else begin
      gcnt_clk_r <= (misc_s2_r[1] != ser_clk_filt) ? gcnt_clk_r + 2'h1 : 2'h0;
      gcnt_dat_r <= (misc_s2_r[0] != ser_data_filt) ? gcnt_dat_r + 2'h1 : 2'h0;
      if (glitch_pass(misc_s2_r[1], ser_clk_filt, gcnt_clk_r, misc_s2_r[2])) begin
        ser_clk_filt <= misc_s2_r[1];
        gcnt_clk_r <= 2'h0;
      end
      if (glitch_pass(misc_s2_r[0], ser_data_filt, gcnt_dat_r, misc_s2_r[2])) begin
        ser_data_filt <= misc_s2_r[0];
        gcnt_dat_r <= 2'h0;
      end
    end
  end

  // Catches the first byte after a start; its last bit gives the direction.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      scl_prev_r <= 1'b1;
      sda_prev_r <= 1'b1;
      sbit_r <= '0;
      sshift_r <= '0;
      sbusy_r <= 1'b0;
      sadr_r <= '0;
      sadr_vld_r <= 1'b0;
    end else begin
      scl_prev_r <= ser_clk_filt;
      sda_prev_r <= ser_data_filt;
      // Start: filtered data falls while the filtered clock stays high.
      if (ser_clk_filt && scl_prev_r && sda_prev_r && !ser_data_filt) begin
        sbusy_r <= 1'b1;
        sbit_r <= '0;
      end else if (sbusy_r && ser_clk_filt && !scl_prev_r) begin
        sshift_r <= {sshift_r[6:0], ser_data_filt};
        sbit_r <= sbit_r + 4'h1;
        if (sbit_r == 4'h7) begin
          sadr_r <= {sshift_r[6:0], ser_data_filt};
          sadr_vld_r <= 1'b1;
          sbusy_r <= 1'b0;
        end
      end
    end
  end

  // APB slave: one wait state, then the answer with pready.
  assign apb_acc = psel && penable && pready;
  assign apb_wr = apb_acc && pwrite && reg_hit(paddr);

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !reg_hit(paddr);
      prdata <= '0;
      if (psel && penable && !pready && !pwrite) begin
        unique case (paddr)
          VPI_CTRL_OFS: prdata <= {25'h0, ctrl_r};
          VPI_STAT_OFS: prdata <= {19'h0, fifo_level, 3'h0, sadr_vld_r,
                                   sadr_r[0], misc_s2_r[2], phase_r, ovf_r};
          VPI_TIME_OFS: prdata <= {lcnt_r, pcnt_r};
          VPI_SADR_OFS: prdata <= {24'h0, sadr_r};
          default: prdata <= '0;
        endcase
      end
    end
  end
endmodule : vpi_top

// file: test/vpi_top_assertions.sv
`timescale 1ns/1ps
module vpi_top_chk (
  input wire logic sys_clk, // Clock.
  input wire logic nrst, // Reset.
  input wire logic psel, // Select.
  input wire logic penable, // Enable.
  input wire logic [7:0] paddr, // Address.
  input wire logic [31:0] prdata, // Read data.
  input wire logic pready, // Ready.
  input wire logic pslverr, // Error.
  input wire logic pixel_clock_input, // Pixel clock.
  input wire logic blank_or_clock_out_out, // Clock out.
  input wire logic blank_or_clock_out_oe, // Clock drive.
  input wire logic addr_lsb_select, // Select pin.
  input wire logic ser_clk_in, // Serial clock.
  input wire logic ser_data_in, // Serial data.
  input wire logic ser_clk_filt, // Filtered clock.
  input wire logic ser_data_filt, // Filtered data.
  input wire logic ser_addr_lsb, // Address bit.
  input wire logic pix_valid, // Word valid.
  input wire logic pix_ready, // Word taken.
  input wire vpi_pkg::vpi_pix_t pix_out // Word.
);
  import vpi_pkg::*;
  // Every check samples on the clock and stands down in reset.
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  // Access phase still waiting for its answer.
  sequence acc_s;
    psel && penable && !pready;
  endsequence
  // A pin held for four samples.
  sequence held_s(s);
    s [*4];
  endsequence
  // A two-sample dip on a serial line that stood high.
  sequence dip_s(s);
    (s && ser_addr_lsb) [*8] ##1 (!s) [*2] ##1 s;
  endsequence
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready stood two cycles");
  unmapped_err_a: assert property (acc_s ##0 (paddr > 8'h0c || paddr[1:0] != 2'h0)
    |=> pready && pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  pix_hold_a: assert property (pix_valid && !pix_ready
    |=> pix_valid && $stable(pix_out))
    else $error("stalled word changed");
  reset_dflt_a: assert property ($rose(nrst) |-> !pready && !pix_valid
    && !blank_or_clock_out_oe && ser_clk_filt && ser_data_filt && !ser_addr_lsb)
    else $error("outputs not at reset values");
  clk_follow_a: assert property (blank_or_clock_out_oe && $rose(pixel_clock_input)
    |-> ##[2:5] $rose(blank_or_clock_out_out))
    else $error("clock output does not follow pixel clock");
  lsb_high_a: assert property (held_s(addr_lsb_select) |-> ser_addr_lsb)
    else $error("address bit not high");
  lsb_low_a: assert property (held_s(!addr_lsb_select) |-> !ser_addr_lsb)
    else $error("address bit not low");
  clk_dip_a: assert property (dip_s(ser_clk_in) |-> ser_clk_filt [*4])
    else $error("serial clock glitch passed");
  dat_dip_a: assert property (dip_s(ser_data_in) |-> ser_data_filt [*4])
    else $error("serial data glitch passed");
endmodule : vpi_top_chk

// file: test/vpi_src_model.sv
`timescale 1ns/1ps
module vpi_src_model (
  input wire logic sys_clk, // Clock.
  input wire logic go, // Start a line.
  input wire logic fmt422, // Two-port format.
  input wire logic [7:0] npix, // Pixels per line.
  output logic pclk, // Pixel clock.
  output logic [vpi_pkg::VPI_CW-1:0] y, // Luma pins.
  output logic [vpi_pkg::VPI_CW-1:0] r, // Red pins.
  output logic [vpi_pkg::VPI_CW-1:0] c, // Chroma pins.
  output logic hs_n, // Line sync.
  output logic vs_n, // Frame sync.
  output logic blank, // Blanking.
  output logic busy // Line running.
);
  import vpi_pkg::*;
  // Idle pins; the pixel clock rests low outside lines.
  initial begin
    pclk = 1'b0;
    y = 10'h155;
    r = 10'h155;
    c = 10'h155;
    hs_n = 1'b1;
    vs_n = 1'b1;
    blank = 1'b0;
    busy = 1'b0;
  end
  // A sync pulse, then one word per pixel clock rise, changed at the fall.
  always @(posedge sys_clk) begin
    if (go) begin
      busy <= 1'b1;
      hs_n <= 1'b0;
      repeat (8) @(posedge sys_clk);
      hs_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
      for (int i = 0; i < npix; i++) begin
        y <= 10'h040 + 10'(i);
        r <= fmt422 ? 10'h2aa ^ 10'(i) : 10'h100 + 10'(i);
        c <= fmt422 ? (i[0] ? 10'h300 : 10'h080) + 10'(i) : 10'h200 + 10'(i);
        repeat (4) @(posedge sys_clk);
        pclk <= 1'b1;
        repeat (4) @(posedge sys_clk);
        pclk <= 1'b0;
      end
      repeat (4) @(posedge sys_clk);
      y <= ~y;
      r <= ~r;
      c <= ~c;
      busy <= 1'b0;
    end
  end
endmodule : vpi_src_model

// file: test/vpi_top_tb.sv
`timescale 1ns/1ps
module vpi_top_tb;
  import vpi_pkg::*;
  logic sys_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic pix_ready = 1'b1, lsb_sel = 1'b0, sclk = 1'b1, sdat = 1'b1, go = 1'b0, f422 = 1'b0;
  logic [7:0] paddr = 8'h0, npix = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, e, pclk, hs_n, vs_n, sblank, busy, bo_out, bo_oe, bo_wire;
  logic sclk_f, sdat_f, s_lsb, pix_valid;
  logic [VPI_CW-1:0] y, r, c;
  logic [6:0] modes [4] = '{7'h60, 7'h62, 7'h61, 7'h61};
  logic [7:0] sbytes [2] = '{8'h5b, 8'h5a};
  vpi_pix_t pix_out;
  vpi_pix_t got [$];
  int num_errors = 0, cmp_count = 0;
  // Clock, and the blank pin level from both drivers.
  always #10 sys_clk = ~sys_clk;
  assign bo_wire = bo_oe ? bo_out : sblank;
  vpi_src_model i_src (.sys_clk, .go, .fmt422(f422), .npix, .pclk, .y, .r, .c, .hs_n,
    .vs_n, .blank(sblank), .busy);
  vpi_top i_dut (.sys_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pixel_clock_input(pclk), .luma_port(y), .red_diff_port(r),
    .shared_chroma_port(c), .line_sync_n(hs_n), .async_secondary_sync(vs_n),
    .blank_or_clock_out_in(bo_wire), .blank_or_clock_out_out(bo_out),
    .blank_or_clock_out_oe(bo_oe), .addr_lsb_select(lsb_sel), .ser_clk_in(sclk),
    .ser_data_in(sdat), .ser_clk_filt(sclk_f), .ser_data_filt(sdat_f),
    .ser_addr_lsb(s_lsb), .pix_valid, .pix_ready, .pix_out);
  // Collect every word the converter side takes.
  always @(posedge sys_clk) begin
    if (nrst && pix_valid === 1'b1 && pix_ready === 1'b1) got.push_back(pix_out);
  end
  task automatic conclude();
    $display("compares %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got_v, input logic [31:0] exp_v);
    cmp_count++;
    if (got_v !== exp_v) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got_v, exp_v);
    end
  endtask : chk
  // A used-up wait bound counts as a mismatch and ends the run.
  task automatic bound(input int k, input int lim);
    if (k >= lim) begin
      num_errors++;
      conclude();
    end
  endtask : bound
  // One APB transfer; q and e take the answer at the ready edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (k = 0; k < 20 && pready !== 1'b1; k++) @(posedge sys_clk);
    bound(k, 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb
  task automatic rdc(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    chk(q & m, x);
  endtask : rdc
  task automatic line(input logic f, input int n);
    int k;
    f422 <= f;
    npix <= 8'(n);
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    @(posedge sys_clk);
    for (k = 0; k < 3000 && busy === 1'b1; k++) @(posedge sys_clk);
    bound(k, 3000);
  endtask : line
  task automatic drain();
    int k;
    for (k = 0; k < 60 && (k < 4 || pix_valid !== 1'b0); k++) @(posedge sys_clk);
    bound(k, 60);
  endtask : drain
  // Word i of a line: luma first, red port second (shared-port Cr in two-port format), shared port third.
  task automatic chk_line(input logic f, input int n);
    chk(got.size(), n);
    foreach (got[i]) begin
      chk(got[i].a, 10'h040 + i);
      if (!f) chk(got[i].b, 10'h100 + i);
      if (!f) chk(got[i].c, 10'h200 + i);
      if (f) chk(got[i].c, 10'h080 + (i & ~1));
      if (f && i > 0) chk(got[i].b, 10'h300 + ((i - 1) | 1));
    end
    got.delete();
  endtask : chk_line
  // Start, eight bits high first, a ninth clock with data released, stop.
  task automatic ser_byte(input logic [7:0] b);
    sdat <= 1'b0;
    repeat (10) @(posedge sys_clk);
    for (int i = 8; i >= 0; i--) begin
      sclk <= 1'b0;
      repeat (5) @(posedge sys_clk);
      sdat <= (i > 0) ? b[i-1] : 1'b1;
      repeat (5) @(posedge sys_clk);
      sclk <= 1'b1;
      repeat (10) @(posedge sys_clk);
    end
    sclk <= 1'b0;
    repeat (5) @(posedge sys_clk);
    sdat <= 1'b0;
    repeat (5) @(posedge sys_clk);
    sclk <= 1'b1;
    repeat (5) @(posedge sys_clk);
    sdat <= 1'b1;
    repeat (10) @(posedge sys_clk);
  endtask : ser_byte
  // Main sequence.
  initial begin
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    rdc(VPI_CTRL_OFS, 32'h60, 32'h7f);
    rdc(VPI_STAT_OFS, 32'h0, 32'h1f01);
    apb(1'b0, 8'h10, 32'h0);
    chk(e, 1);
    chk(q, 0);
    foreach (modes[m]) begin
      apb(1'b1, VPI_CTRL_OFS, {25'h0, modes[m]});
      line(modes[m][0], 5);
      drain();
      chk_line(modes[m][0], 5);
    end
    pix_ready <= 1'b0;
    line(1'b0, 20);
    rdc(VPI_STAT_OFS, 32'h1001, 32'h1f01);
    pix_ready <= 1'b1;
    drain();
    chk(got.size() >= 16, 1);
    for (int i = 0; i < 16; i++) chk(got[i].a, 10'h040 + i);
    got.delete();
    apb(1'b1, VPI_STAT_OFS, 32'h1);
    rdc(VPI_STAT_OFS, 32'h0, 32'h1f01);
    apb(1'b1, VPI_CTRL_OFS, 32'h70);
    line(1'b0, 3);
    chk(bo_oe, 1);
    drain();
    got.delete();
    apb(1'b1, VPI_CTRL_OFS, 32'h50);
    @(posedge sys_clk);
    chk(bo_oe, 0);
    apb(1'b1, VPI_CTRL_OFS, 32'h7f);
    rdc(VPI_CTRL_OFS, 32'h7f, 32'h7f);
    nrst <= 1'b0;
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    rdc(VPI_CTRL_OFS, 32'h60, 32'h7f);
    lsb_sel <= 1'b1;
    repeat (12) @(posedge sys_clk);
    chk(s_lsb, 1);
    rdc(VPI_STAT_OFS, 32'h4, 32'h4);
    sclk <= 1'b0;
    sdat <= 1'b0;
    repeat (2) @(posedge sys_clk);
    sclk <= 1'b1;
    sdat <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk);
      chk({sclk_f, sdat_f}, 2'b11);
    end
    sclk <= 1'b0;
    repeat (10) @(posedge sys_clk);
    chk(sclk_f, 0);
    sclk <= 1'b1;
    repeat (10) @(posedge sys_clk);
    foreach (sbytes[j]) begin
      ser_byte(sbytes[j]);
      rdc(VPI_SADR_OFS, {24'h0, sbytes[j]}, 32'hff);
      rdc(VPI_STAT_OFS, {27'h0, 1'b1, sbytes[j][0], 3'h0}, 32'h18);
    end
    conclude();
  end
endmodule : vpi_top_tb
bind vpi_top vpi_top_chk i_chk (.sys_clk, .nrst, .psel, .penable, .paddr, .prdata, .pready,
  .pslverr, .pixel_clock_input, .blank_or_clock_out_out, .blank_or_clock_out_oe,
  .addr_lsb_select, .ser_clk_in, .ser_data_in, .ser_clk_filt, .ser_data_filt,
  .ser_addr_lsb, .pix_valid, .pix_ready, .pix_out);
